// [include/rf_cfg_pkg.sv]
// constants shared by the configuration decode block
`default_nettype none
package rf_cfg_pkg;
    // serial frame: 5-bit register index then 27 data bits, msb first
    localparam int unsigned FRAME_BITS = 32;
    localparam int unsigned ADDR_BITS  = 5;
    localparam int unsigned DATA_BITS  = 27;
    localparam int unsigned CNT_BITS   = 6;

    // register indices
    localparam logic [4:0] IDX_GPO_CTRL = 5'h07;
    localparam logic [4:0] IDX_OUT_ONE  = 5'h17;
    localparam logic [4:0] IDX_REF_CTRL = 5'h1d;
    localparam logic [4:0] IDX_RX_GAIN  = 5'h02;

    // field positions
    localparam int unsigned OUT_THREE_LEVEL_BIT = 0;
    localparam int unsigned OUT_THREE_LOCK_BIT  = 1;
    localparam int unsigned OUT_TWO_LSB         = 2;
    localparam int unsigned OUT_ONE_LSB         = 24;
    localparam int unsigned REF_EN_BIT      = 14;
    localparam int unsigned REF_SWING_BIT   = 23;
    localparam int unsigned INPUT_SEL_LSB   = 0;
    localparam int unsigned BB_GAIN_LSB     = 8;
    localparam int unsigned LNA_GAIN_LSB    = 14;

    // gain step of the baseband amplifier per code lsb, in dB
    localparam logic [5:0] BB_STEP_DB = 6'h03;

    // reset values
    localparam logic [26:0] RST_GPO_CTRL = 27'h0;
    localparam logic [26:0] RST_OUT_ONE  = 27'h0;
    localparam logic [26:0] RST_REF_CTRL = 27'h0;
    localparam logic [26:0] RST_RX_GAIN  = 27'h0;
    // pin synchronisers start at idle levels: select high, rest low
    localparam logic [5:0]  RST_PIN_SYNC = 6'h02;

    // wishbone byte addresses
    localparam logic [7:0] WB_ADR_GPO_CTRL = 8'h1c;
    localparam logic [7:0] WB_ADR_OUT_ONE  = 8'h5c;
    localparam logic [7:0] WB_ADR_REF_CTRL = 8'h74;
    localparam logic [7:0] WB_ADR_RX_GAIN  = 8'h08;
    localparam logic [7:0] WB_ADR_STATUS   = 8'h80;

    typedef enum logic [1:0] {LNA_HIGH, LNA_MED, LNA_LOW} lna_state_t;
    typedef enum logic {SER_IDLE, SER_SHIFT} ser_state_t;
endpackage
`default_nettype wire

// [design/serial_write_rx.sv]
// serial write receiver: shifts frames on sclk rising edges
`timescale 1ns/1ns
`default_nettype none
module serial_write_rx
    import rf_cfg_pkg::*;
(
    input  wire logic                 i_clk,
    input  wire logic                 i_sys_rst,
    input  wire logic                 i_sclk,
    input  wire logic                 i_cs_n,
    input  wire logic                 i_din,
    output logic                      o_valid,
    output logic [rf_cfg_pkg::ADDR_BITS-1:0] o_addr,
    output logic [rf_cfg_pkg::DATA_BITS-1:0] o_data
);
    ser_state_t              state_reg;
    ser_state_t              state_next;
    logic                    sclk_prev_reg;
    logic [FRAME_BITS-1:0]   shift_reg;
    logic [FRAME_BITS-1:0]   shift_next;
    logic [CNT_BITS-1:0]     cnt_reg;
    logic [CNT_BITS-1:0]     cnt_next;
    logic                    valid_next;
    logic                    rise;

    assign rise   = i_sclk & ~sclk_prev_reg;
    assign o_addr = shift_reg[FRAME_BITS-1 -: ADDR_BITS];
    assign o_data = shift_reg[DATA_BITS-1:0];

    always_comb
    begin
        state_next = state_reg;
        shift_next = shift_reg;
        cnt_next   = cnt_reg;
        valid_next = 1'b0;
        case (state_reg)
            SER_IDLE:
            begin
                if (!i_cs_n)
                begin
                    state_next = SER_SHIFT;
                    cnt_next   = '0;
                end
            end
            SER_SHIFT:
            begin
                if (i_cs_n)
                begin
                    // only a whole frame is handed on
                    valid_next = (cnt_reg == CNT_BITS'(FRAME_BITS));
                    state_next = SER_IDLE;
                end
                else if (rise)
                begin
                    shift_next = {shift_reg[FRAME_BITS-2:0], i_din};
                    if (cnt_reg <= CNT_BITS'(FRAME_BITS))
                    begin
                        cnt_next = cnt_reg + 1'b1;
                    end
                end
            end
            default:
            begin
                state_next = SER_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            state_reg     <= SER_IDLE;
            shift_reg     <= '0;
            cnt_reg       <= '0;
            o_valid       <= 1'b0;
            sclk_prev_reg <= 1'b0;
        end
        else
        begin
            state_reg     <= state_next;
            shift_reg     <= shift_next;
            cnt_reg       <= cnt_next;
            o_valid       <= valid_next;
            sclk_prev_reg <= i_sclk;
        end
    end
endmodule
`default_nettype wire

// [design/rf_transceiver_config_decode.sv]
// configuration decode: serial and wishbone writes to control outputs
`timescale 1ns/1ns
`default_nettype none
module rf_transceiver_config_decode
    import rf_cfg_pkg::*;
(
    input  wire logic        i_clk,
    input  wire logic        i_sys_rst,
    input  wire logic        i_wb_cyc,
    input  wire logic        i_wb_stb,
    input  wire logic        i_wb_we,
    input  wire logic [7:0]  i_wb_adr,
    input  wire logic [3:0]  i_wb_sel,
    input  wire logic [31:0] i_wb_dat,
    output logic [31:0]      o_wb_dat,
    output logic             o_wb_ack,
    input  wire logic        i_sclk,
    input  wire logic        i_cs_n,
    input  wire logic        i_din,
    output logic             o_dout,
    input  wire logic        i_ref_output_strap,
    input  wire logic        i_ref_clock_in,
    input  wire logic        i_pll_lock,
    output logic             o_ref_clock_out,
    output logic             o_ref_out_active,
    output logic             o_ref_out_low_swing,
    output logic             o_general_output_one,
    output logic             o_general_output_two,
    output logic             o_general_output_three,
    output logic [1:0]       o_lna_gain_state,
    output logic [3:0]       o_baseband_gain_code,
    output logic [5:0]       o_baseband_gain_db,
    output logic [4:0]       o_rf_input_enable,
    output logic             o_monitor_mode
);
    localparam int unsigned NSYNC = 6;

    // two-stage synchronisers for every pin input
    logic [NSYNC-1:0] pin_raw;
    logic [NSYNC-1:0] sync1_reg;
    logic [NSYNC-1:0] sync2_reg;
    assign pin_raw = {i_pll_lock, i_ref_clock_in, i_ref_output_strap,
                      i_din, i_cs_n, i_sclk};

    genvar g;
    generate
        for (g = 0; g < NSYNC; g++)
        begin : g_sync
            always_ff @(posedge i_clk)
            begin
                if (i_sys_rst)
                begin
                    sync1_reg[g] <= RST_PIN_SYNC[g];
                    sync2_reg[g] <= RST_PIN_SYNC[g];
                end
                else
                begin
                    sync1_reg[g] <= pin_raw[g];
                    sync2_reg[g] <= sync1_reg[g];
                end
            end
        end
    endgenerate

    logic sclk_s;
    logic cs_n_s;
    logic din_s;
    logic strap_s;
    logic ref_in_s;
    logic lock_s;
    assign sclk_s  = sync2_reg[0];
    assign cs_n_s  = sync2_reg[1];
    assign din_s   = sync2_reg[2];
    assign strap_s = sync2_reg[3];
    assign ref_in_s = sync2_reg[4];
    assign lock_s  = sync2_reg[5];

    logic                 ser_valid;
    logic [ADDR_BITS-1:0] ser_addr;
    logic [DATA_BITS-1:0] ser_data;

    serial_write_rx u_rx (
        .i_clk     (i_clk),
        .i_sys_rst (i_sys_rst),
        .i_sclk    (sclk_s),
        .i_cs_n    (cs_n_s),
        .i_din     (din_s),
        .o_valid   (ser_valid),
        .o_addr    (ser_addr),
        .o_data    (ser_data)
    );

    // configuration registers
    logic [DATA_BITS-1:0] gpo_ctrl_reg;
    logic [DATA_BITS-1:0] gpo_ctrl_next;
    logic [DATA_BITS-1:0] out_one_reg;
    logic [DATA_BITS-1:0] out_one_next;
    logic [DATA_BITS-1:0] ref_ctrl_reg;
    logic [DATA_BITS-1:0] ref_ctrl_next;
    logic [DATA_BITS-1:0] rx_gain_reg;
    logic [DATA_BITS-1:0] rx_gain_next;
    logic                 ack_next;
    logic [31:0]          rdat_next;
    logic                 wb_req;
    logic [31:0]          wmask;
    logic [31:0]          status_word;

    assign wb_req = i_wb_cyc & i_wb_stb & ~o_wb_ack;
    assign wmask  = {{8{i_wb_sel[3]}}, {8{i_wb_sel[2]}},
                     {8{i_wb_sel[1]}}, {8{i_wb_sel[0]}}};
    assign status_word = {24'h0, o_monitor_mode, lock_s, ref_in_s,
                          strap_s, 4'h0};

    function automatic logic [DATA_BITS-1:0] merge(
        input logic [DATA_BITS-1:0] old,
        input logic [31:0]          dat,
        input logic [31:0]          msk
    );
        logic [31:0] t;
        t = ({5'h0, old} & ~msk) | (dat & msk);
        return t[DATA_BITS-1:0];
    endfunction

    always_comb
    begin
        gpo_ctrl_next = gpo_ctrl_reg;
        out_one_next  = out_one_reg;
        ref_ctrl_next = ref_ctrl_reg;
        rx_gain_next  = rx_gain_reg;
        ack_next      = wb_req;
        rdat_next     = 32'h0;
        // a finished serial frame loads its register
        if (ser_valid)
        begin
            case (ser_addr)
                IDX_GPO_CTRL: gpo_ctrl_next = ser_data;
                IDX_OUT_ONE:  out_one_next  = ser_data;
                IDX_REF_CTRL: ref_ctrl_next = ser_data;
                IDX_RX_GAIN:  rx_gain_next  = ser_data;
                default:      gpo_ctrl_next = gpo_ctrl_reg;
            endcase
        end
        // wishbone write wins if both land together
        if (wb_req)
        begin
            case (i_wb_adr)
                WB_ADR_GPO_CTRL:
                begin
                    rdat_next = {5'h0, gpo_ctrl_reg};
                    if (i_wb_we)
                        gpo_ctrl_next = merge(gpo_ctrl_reg, i_wb_dat, wmask);
                end
                WB_ADR_OUT_ONE:
                begin
                    rdat_next = {5'h0, out_one_reg};
                    if (i_wb_we)
                        out_one_next = merge(out_one_reg, i_wb_dat, wmask);
                end
                WB_ADR_REF_CTRL:
                begin
                    rdat_next = {5'h0, ref_ctrl_reg};
                    if (i_wb_we)
                        ref_ctrl_next = merge(ref_ctrl_reg, i_wb_dat, wmask);
                end
                WB_ADR_RX_GAIN:
                begin
                    rdat_next = {5'h0, rx_gain_reg};
                    if (i_wb_we)
                        rx_gain_next = merge(rx_gain_reg, i_wb_dat, wmask);
                end
                WB_ADR_STATUS: rdat_next = status_word;
                default:       rdat_next = 32'h0;
            endcase
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            gpo_ctrl_reg <= RST_GPO_CTRL;
            out_one_reg  <= RST_OUT_ONE;
            ref_ctrl_reg <= RST_REF_CTRL;
            rx_gain_reg  <= RST_RX_GAIN;
            o_wb_ack     <= 1'b0;
            o_wb_dat     <= 32'h0;
        end
        else
        begin
            gpo_ctrl_reg <= gpo_ctrl_next;
            out_one_reg  <= out_one_next;
            ref_ctrl_reg <= ref_ctrl_next;
            rx_gain_reg  <= rx_gain_next;
            o_wb_ack     <= ack_next;
            o_wb_dat     <= rdat_next;
        end
    end

    // output decode
    logic       ref_clk_next;
    logic       refact_next;
    logic       reflv_next;
    logic       gen_one_next;
    logic       gen_two_next;
    logic       gen_three_next;
    lna_state_t lna_next;
    logic [3:0] bb_code;
    logic [1:0] lna_code;
    logic [2:0] in_sel;
    logic [4:0] in_en_next;
    logic       mon_next;

    assign bb_code  = rx_gain_reg[BB_GAIN_LSB +: 4];
    assign lna_code = rx_gain_reg[LNA_GAIN_LSB +: 2];
    assign in_sel   = rx_gain_reg[INPUT_SEL_LSB +: 3];

    // two-bit output field: 00 low, 01 high, 1x pll lock
    function automatic logic gpo_field(
        input logic [1:0] f,
        input logic       lock
    );
        return f[1] ? lock : f[0];
    endfunction

    always_comb
    begin
        ref_clk_next = 1'b0;
        refact_next  = 1'b0;
        reflv_next   = 1'b0;
        if (strap_s)
        begin
            ref_clk_next = ref_in_s;
            refact_next  = 1'b1;
        end
        else if (ref_ctrl_reg[REF_EN_BIT])
        begin
            ref_clk_next = ref_in_s;
            refact_next  = 1'b1;
            reflv_next   = ref_ctrl_reg[REF_SWING_BIT];
        end
        gen_one_next   = gpo_field(out_one_reg[OUT_ONE_LSB +: 2],
                                   lock_s);
        gen_two_next   = gpo_field(gpo_ctrl_reg[OUT_TWO_LSB +: 2],
                                   lock_s);
        gen_three_next = gpo_ctrl_reg[OUT_THREE_LOCK_BIT] ? lock_s
                       : gpo_ctrl_reg[OUT_THREE_LEVEL_BIT];
        case (lna_code)
            2'b00:   lna_next = LNA_HIGH;
            2'b01:   lna_next = LNA_MED;
            default: lna_next = LNA_LOW;
        endcase
        if (in_sel == 3'h4)
        begin
            lna_next = (lna_code == 2'b00) ? LNA_HIGH : LNA_LOW;
        end
        // select codes 1..5 name the inputs, others leave all off
        in_en_next = 5'h0;
        mon_next   = 1'b0;
        case (in_sel)
            3'h1: in_en_next = 5'h01;
            3'h2:
            begin
                in_en_next = 5'h02;
                mon_next   = 1'b1;
            end
            3'h3: in_en_next = 5'h04;
            3'h4:
            begin
                in_en_next = 5'h08;
                mon_next   = 1'b1;
            end
            3'h5:
            begin
                in_en_next = 5'h10;
                mon_next   = 1'b1;
            end
            default: in_en_next = 5'h0;
        endcase
    end

    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            o_ref_clock_out        <= 1'b0;
            o_ref_out_active       <= 1'b0;
            o_ref_out_low_swing    <= 1'b0;
            o_general_output_one   <= 1'b0;
            o_general_output_two   <= 1'b0;
            o_general_output_three <= 1'b0;
            o_lna_gain_state       <= LNA_HIGH;
            o_baseband_gain_code   <= 4'h0;
            o_baseband_gain_db     <= 6'h0;
            o_rf_input_enable      <= 5'h0;
            o_monitor_mode         <= 1'b0;
            o_dout                 <= 1'b0;
        end
        else
        begin
            o_ref_clock_out        <= ref_clk_next;
            o_ref_out_active       <= refact_next;
            o_ref_out_low_swing    <= reflv_next;
            o_general_output_one   <= gen_one_next;
            o_general_output_two   <= gen_two_next;
            o_general_output_three <= gen_three_next;
            o_lna_gain_state       <= lna_next;
            o_baseband_gain_code   <= bb_code;
            o_baseband_gain_db     <= 6'({2'h0, bb_code} * BB_STEP_DB);
            o_rf_input_enable      <= in_en_next;
            o_monitor_mode         <= mon_next;
            o_dout                 <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// [sim/rf_cfg_decode_asserts.sv]
// concurrent checks on the configuration decode ports
`timescale 1ns/1ns
`default_nettype none
module rf_cfg_decode_asserts (
    input  wire logic       i_clk,
    input  wire logic       i_sys_rst,
    input  wire logic       i_wb_cyc,
    input  wire logic       i_wb_stb,
    input  wire logic       o_wb_ack,
    input  wire logic       i_cs_n,
    input  wire logic       i_ref_output_strap,
    input  wire logic       o_ref_clock_out,
    input  wire logic       o_ref_out_active,
    input  wire logic       o_ref_out_low_swing,
    input  wire logic [1:0] o_lna_gain_state,
    input  wire logic [3:0] o_baseband_gain_code,
    input  wire logic [5:0] o_baseband_gain_db,
    input  wire logic [4:0] o_rf_input_enable,
    input  wire logic       o_monitor_mode
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    ack_answer_a:
        assert property ((i_wb_cyc && i_wb_stb && !o_wb_ack) |=> o_wb_ack)
        else $error("wishbone request not acknowledged next cycle");
    ack_pulse_a:
        assert property (o_wb_ack |=> !o_wb_ack)
        else $error("wishbone ack longer than one cycle");
    strap_cmos_a:
        assert property (i_ref_output_strap [*5] |->
            o_ref_out_active && !o_ref_out_low_swing)
        else $error("strap high but reference output not cmos buffer");
    ref_off_a:
        assert property (!o_ref_out_active |-> !o_ref_clock_out)
        else $error("reference output toggles while off");
    gain_db_a:
        assert property (o_baseband_gain_db == 6'(o_baseband_gain_code * 3))
        else $error("baseband gain not three dB per step");
    input_onehot_a:
        assert property ($onehot0(o_rf_input_enable))
        else $error("more than one rf input enabled");
    monitor_map_a:
        assert property (o_monitor_mode == |(o_rf_input_enable & 5'h1a))
        else $error("monitor flag disagrees with selected input");
    lna_code_a:
        assert property (o_lna_gain_state != 2'h3)
        else $error("lna gain state outside high medium low");
    lna_four_a:
        assert property (o_rf_input_enable[3] |-> o_lna_gain_state != 2'h1)
        else $error("input four given medium gain");
    frame_hold_a:
        assert property ((!i_cs_n && !i_wb_cyc) [*8] |->
            $stable(o_baseband_gain_code) && $stable(o_lna_gain_state))
        else $error("gain changed during a serial frame");
endmodule
bind rf_transceiver_config_decode rf_cfg_decode_asserts chk_u (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_wb_cyc(i_wb_cyc),
    .i_wb_stb(i_wb_stb), .o_wb_ack(o_wb_ack), .i_cs_n(i_cs_n),
    .i_ref_output_strap(i_ref_output_strap),
    .o_ref_clock_out(o_ref_clock_out), .o_ref_out_active(o_ref_out_active),
    .o_ref_out_low_swing(o_ref_out_low_swing),
    .o_lna_gain_state(o_lna_gain_state),
    .o_baseband_gain_code(o_baseband_gain_code),
    .o_baseband_gain_db(o_baseband_gain_db),
    .o_rf_input_enable(o_rf_input_enable), .o_monitor_mode(o_monitor_mode));
`default_nettype wire

// [sim/bb_serial_master.sv]
// baseband side serial master: sends one frame per request
`timescale 1ns/1ns
`default_nettype none
module bb_serial_master (
    input  wire logic        i_go,
    input  wire logic [31:0] i_word,
    input  wire logic [5:0]  i_nbits,
    output logic             o_sclk,
    output logic             o_cs_n,
    output logic             o_din,
    output logic             o_done
);
    int i;
    initial
    begin
        o_sclk = 1'b0;
        o_cs_n = 1'b1;
        o_din  = 1'b0;
        o_done = 1'b0;
    end
    // sclk stands still outside frames
    always @(posedge i_go)
    begin
        o_done = 1'b0;
        o_cs_n = 1'b0;
        for (i = 31; i > 31 - int'(i_nbits); i--)
        begin
            o_din = i_word[i];
            #24 o_sclk = 1'b1;
            #24 o_sclk = 1'b0;
        end
        // released data line no longer shows the last bit
        o_din = ~o_din;
        #24 o_cs_n = 1'b1;
        #24 o_done = 1'b1;
    end
endmodule
`default_nettype wire

// [sim/rf_transceiver_config_decode_bench.sv]
// bench: wishbone and serial writes checked at the decode outputs
`timescale 1ns/1ns
`default_nettype none
module rf_transceiver_config_decode_bench;
    import rf_cfg_pkg::*;
    logic        clk, rst, cyc, stb, we, strap, lock, go, sclk, cs_n, din;
    logic        done, dout, ack, rco, act, lsw, g1, g2, g3, mon;
    logic [7:0]  adr;
    logic [31:0] wdat, rdat, q, word;
    logic [5:0]  nbits, db;
    logic [2:0]  rc = 3'h0, rc_hist = 3'h0;
    logic [3:0]  sel;
    logic [1:0]  lna;
    logic [3:0]  code;
    logic [4:0]  ien;
    int          errors, total_checks, s, k;

    rf_transceiver_config_decode dut_u (
        .i_clk(clk), .i_sys_rst(rst), .i_wb_cyc(cyc), .i_wb_stb(stb),
        .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat),
        .o_wb_dat(rdat), .o_wb_ack(ack), .i_sclk(sclk), .i_cs_n(cs_n),
        .i_din(din), .o_dout(dout), .i_ref_output_strap(strap),
        .i_ref_clock_in(rc[2]), .i_pll_lock(lock), .o_ref_clock_out(rco),
        .o_ref_out_active(act), .o_ref_out_low_swing(lsw),
        .o_general_output_one(g1), .o_general_output_two(g2),
        .o_general_output_three(g3), .o_lna_gain_state(lna),
        .o_baseband_gain_code(code), .o_baseband_gain_db(db),
        .o_rf_input_enable(ien), .o_monitor_mode(mon));
    bb_serial_master master_u (
        .i_go(go), .i_word(word), .i_nbits(nbits), .o_sclk(sclk),
        .o_cs_n(cs_n), .o_din(din), .o_done(done));

    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) rc <= rc + 3'h1;
    // ref pin as seen three edges earlier, the decode's pipeline depth
    always @(posedge clk) rc_hist <= {rc_hist[1:0], rc[2]};

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, input logic [3:0] m = 4'hf);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= m;
        do @(posedge clk); while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        repeat (3) @(posedge clk);
    endtask
    task automatic ser(input logic [4:0] idx, input logic [26:0] d,
                       input logic [5:0] nb);
        word <= {idx, d};
        nbits <= nb;
        go <= 1'b1;
        do @(posedge clk); while (done !== 1'b1);
        go <= 1'b0;
        repeat (12) @(posedge clk);
    endtask
    task automatic wrap_up;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial
    begin
        #200000;
        errors++;
        wrap_up();
    end
    initial
    begin
        {cyc, stb, we, strap, lock, go, errors, total_checks} = '0;
        {adr, wdat, word, nbits, sel} = '0;
        rst = 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        chk({ien, lna, code, db, act, g1, g2, g3}, 32'h0);
        for (s = 1; s <= 5; s++)
        begin
            ser(IDX_RX_GAIN, 27'(32'h4000 | ((s + 10) << 8) | s), 6'h20);
            chk(code, s + 10);
            chk(db, (s + 10) * 3);
            chk(ien, 1 << (s - 1));
            chk(mon, s == 2 || s == 4 || s == 5);
            chk(lna, s == 4 ? 2 : 1);
        end
        ser(IDX_RX_GAIN, 27'h0000001, 6'h1f);
        chk({code, ien}, {4'hf, 5'h10});
        wb(1'b1, WB_ADR_RX_GAIN, 32'hffff_ffff);
        wb(1'b0, WB_ADR_RX_GAIN, 32'h0);
        chk(q, 32'h07ff_ffff);
        chk({lna, ien, db}, {2'h2, 5'h00, 6'h2d});
        wb(1'b1, WB_ADR_RX_GAIN, 32'h0000_0004);
        chk({lna, ien, mon}, {2'h0, 5'h08, 1'b1});
        wb(1'b1, WB_ADR_RX_GAIN, 32'hffff_ff00, 4'h2);
        chk({lna, ien, code}, {2'h2, 5'h08, 4'hf});
        wb(1'b0, 8'h40, 32'h0);
        chk(q, 32'h0);
        wb(1'b1, WB_ADR_GPO_CTRL, 32'h0000_0005);
        chk({g1, g2, g3}, 3'b011);
        wb(1'b1, WB_ADR_OUT_ONE, 32'h0100_0000);
        chk(g1, 1'b1);
        wb(1'b1, WB_ADR_GPO_CTRL, 32'h0000_000a);
        wb(1'b1, WB_ADR_OUT_ONE, 32'h0200_0000);
        for (k = 1; k >= 0; k--)
        begin
            lock <= k[0];
            repeat (5) @(posedge clk);
            chk({g1, g2, g3}, {3{k[0]}});
        end
        ser(IDX_REF_CTRL, 27'h0804000, 6'h20);
        chk({act, lsw}, 2'b11);
        strap <= 1'b1;
        repeat (8) @(posedge clk);
        chk({act, lsw}, 2'b10);
        for (k = 0; k < 8; k++)
        begin
            @(posedge clk);
            chk(rco, rc_hist[2]);
        end
        wb(1'b0, WB_ADR_STATUS, 32'h0);
        chk(q & 32'hffff_ffdf, 32'h0000_0090);
        chk(dout, 1'b0);
        strap <= 1'b0;
        ser(IDX_REF_CTRL, 27'h0800000, 6'h20);
        chk({act, rco}, 2'b00);
        wrap_up();
    end
endmodule
`default_nettype wire
